// >>> pkg/dsol_cfg.svh
// drive status output logic: offsets, field positions, reset values, timing
// assumes a 32-bit ahb-lite register bus and a 40 MHz clock
`ifndef DSOL_CFG_SVH
`define DSOL_CFG_SVH
// register byte offsets
`define DSOL_OFS_CTRL 8'h00
`define DSOL_OFS_ALLOC 8'h04
`define DSOL_OFS_ROT_THR 8'h08
`define DSOL_OFS_VM_WIDTH 8'h0C
`define DSOL_OFS_PD_WIDTH 8'h10
`define DSOL_OFS_PD_TIMING 8'h14
`define DSOL_OFS_STATUS 8'h18
`define DSOL_OFS_IRQ_STAT 8'h1C
`define DSOL_OFS_IRQ_MASK 8'h20
// control fields
`define DSOL_CTRL_POS_MODE 0
`define DSOL_CTRL_ABS_ENC 1
`define DSOL_CTRL_RESTART 2
// status bit positions (status, irq status and irq mask share them)
`define DSOL_EV_WARN 0
`define DSOL_EV_ROT 1
`define DSOL_EV_RDY 2
`define DSOL_EV_VM 3
`define DSOL_EV_PD 4
`define DSOL_NUM_EV 5
`define DSOL_ST_TIMING_LSB 5
`define DSOL_ST_ENC_ON 7
// setting ranges and reset values
`define DSOL_ROT_THR_MIN 14'h0001
`define DSOL_ROT_THR_MAX 14'h2710
`define DSOL_ROT_THR_RST 14'h0014
`define DSOL_VM_WIDTH_MAX 7'h64
`define DSOL_VM_WIDTH_RST 7'h0A
`define DSOL_PD_WIDTH_MAX 31'h40000000
`define DSOL_PD_WIDTH_RST 31'h00000007
`define DSOL_NUM_PINS 3
// control cycle timing
`define DSOL_CLK_PERIOD_NS 25
`define DSOL_CTRL_CYCLE_NS 62500
`define DSOL_CTRL_CYCLES (`DSOL_CTRL_CYCLE_NS / `DSOL_CLK_PERIOD_NS)
`endif

// >>> pkg/dsol_pkg.sv
// drive status output logic: shared types
// assumes dsol_cfg.svh supplies the numeric constants
package dsol_pkg;
  // pin allocation code: 0 leaves the signal off every pin, n picks pin n-1
  typedef logic [1:0] dsol_alloc_t;
  typedef logic [2:0] dsol_pins_t;
  // positioning done timing choices
  typedef enum logic [1:0] {
    DSOL_PD_ERR_ONLY = 2'b00,
    DSOL_PD_FILT_ZERO = 2'b01,
    DSOL_PD_RAW_ZERO = 2'b10
  } dsol_pd_timing_t;
endpackage

// >>> hdl/dsol_core.sv
// drive status output logic: warning, rotation detect, servo ready,
// speed match and positioning done, mapped onto output pins
// assumes an ahb-lite master on hclk and inputs synchronous to hclk
//
// Contract
// [R1] warning output active while a warning is present, inactive otherwise
// [R2] each status reaches a pin only through its own allocation field
// [R3] rotation detect high while speed at or above threshold
// [R4] rotation threshold 1..10000 rpm, default 20, effective immediately
// [R5] servo ready needs main power, no safety block, no alarm, encoder on
// [R6] absolute data sent before encoder power-on command is accepted
// [R7] speed match while speed difference below width 0..100, default 10
// [R8] speed match produced only in speed control mode
// [R9] positioning done in position mode when error below width
// [R10] positioning width 0..1073741824, default 7, effective immediately
// [R11] timing select 0/1/2 adds filtered or raw zero, applies after restart
// [R12] host lowers the width if positioning done shows spuriously
// [R13] comparisons registered once per control cycle and held between
`timescale 1ns/1ps
`include "dsol_cfg.svh"
module dsol_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [15:0] reference_speed,
  input wire logic signed [31:0] position_error,
  input wire logic filtered_ref_zero,
  input wire logic raw_ref_zero,
  input wire logic main_power_on,
  input wire logic hardwired_safety_block,
  input wire logic alarm_active,
  input wire logic warning_active,
  input wire logic encoder_power_on_command,
  input wire logic abs_data_sent,
  output dsol_pkg::dsol_pins_t status_pins,
  output logic irq
);
  import dsol_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // control cycle divider
  logic [11:0] div_q, div_d;
  logic tick;
  always_comb begin
    tick = (div_q == 12'(`DSOL_CTRL_CYCLES - 1));
    div_d = tick ? 12'h000 : div_q + 12'h001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_q <= 12'h000;
    else div_q <= div_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture; zero wait states, always okay
  logic wr_q, wr_d, rd_q, rd_d;
  logic [7:0] adr_q, adr_d;
  always_comb begin
    wr_d = hsel && htrans[1] && hready && hwrite;
    rd_d = hsel && htrans[1] && hready && !hwrite;
    adr_d = (hsel && htrans[1] && hready) ? haddr[7:0] : adr_q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      adr_q <= adr_d;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // settings registers; out-of-range writes are dropped, old value kept
  logic [1:0] mode_q, mode_d;
  logic [9:0] alloc_q, alloc_d;
  logic [13:0] rot_thr_q, rot_thr_d;
  logic [6:0] vm_w_q, vm_w_d;
  logic [30:0] pd_w_q, pd_w_d;
  logic [1:0] tim_pend_q, tim_pend_d;
  dsol_pd_timing_t tim_act_q, tim_act_d;
  logic [`DSOL_NUM_EV-1:0] imask_q, imask_d;
  logic restart;
  always_comb begin
    mode_d = mode_q;
    alloc_d = alloc_q;
    rot_thr_d = rot_thr_q;
    vm_w_d = vm_w_q;
    pd_w_d = pd_w_q;
    tim_pend_d = tim_pend_q;
    tim_act_d = tim_act_q;
    imask_d = imask_q;
    restart = wr_q && (adr_q == `DSOL_OFS_CTRL) && hwdata[`DSOL_CTRL_RESTART];
    if (wr_q) begin
      case (adr_q)
        `DSOL_OFS_CTRL: mode_d = hwdata[1:0];
        `DSOL_OFS_ALLOC: alloc_d = hwdata[9:0];
        `DSOL_OFS_ROT_THR: begin
          // see [R4]
          if (hwdata[31:14] == 18'h00000 && hwdata[13:0] >= `DSOL_ROT_THR_MIN
              && hwdata[13:0] <= `DSOL_ROT_THR_MAX) rot_thr_d = hwdata[13:0];
        end
        `DSOL_OFS_VM_WIDTH: begin
          // see [R7]
          if (hwdata[31:7] == 25'h0000000 && hwdata[6:0] <= `DSOL_VM_WIDTH_MAX)
            vm_w_d = hwdata[6:0];
        end
        `DSOL_OFS_PD_WIDTH: begin
          // see [R10]
          if (!hwdata[31] && hwdata[30:0] <= `DSOL_PD_WIDTH_MAX) pd_w_d = hwdata[30:0];
        end
        `DSOL_OFS_PD_TIMING: begin
          if (hwdata[1:0] != 2'b11) tim_pend_d = hwdata[1:0];
        end
        `DSOL_OFS_IRQ_MASK: imask_d = hwdata[`DSOL_NUM_EV-1:0];
        default: ;
      endcase
    end
    // pending timing choice only takes over on a restart; see [R11]
    if (restart) tim_act_d = dsol_pd_timing_t'(tim_pend_q);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= 2'b00;
      alloc_q <= 10'h000;
      rot_thr_q <= `DSOL_ROT_THR_RST;
      vm_w_q <= `DSOL_VM_WIDTH_RST;
      pd_w_q <= `DSOL_PD_WIDTH_RST;
      tim_pend_q <= 2'b00;
      tim_act_q <= DSOL_PD_ERR_ONLY;
      imask_q <= 5'h00;
    end else begin
      mode_q <= mode_d;
      alloc_q <= alloc_d;
      rot_thr_q <= rot_thr_d;
      vm_w_q <= vm_w_d;
      pd_w_q <= pd_w_d;
      tim_pend_q <= tim_pend_d;
      tim_act_q <= tim_act_d;
      imask_q <= imask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status evaluation, sampled once per control cycle; see [R13]
  logic [15:0] spd_abs;
  logic [16:0] dif_abs;
  logic [31:0] err_abs;
  logic signed [16:0] dif;
  logic enc_ok, pos_mode;
  logic [`DSOL_NUM_EV-1:0] st_q, st_d, ev;
  always_comb begin
    pos_mode = mode_q[`DSOL_CTRL_POS_MODE];
    spd_abs = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
    dif = 17'(reference_speed) - 17'(motor_speed);
    dif_abs = dif[16] ? 17'(-dif) : 17'(dif);
    err_abs = position_error[31] ? 32'(-position_error) : 32'(position_error);
    // command counts only once absolute data has gone out; see [R6]
    enc_ok = !mode_q[`DSOL_CTRL_ABS_ENC] || (encoder_power_on_command && abs_data_sent);
    st_d = st_q;
    if (tick) begin
      st_d[`DSOL_EV_WARN] = warning_active; // see [R1]
      st_d[`DSOL_EV_ROT] = spd_abs >= {2'b00, rot_thr_q}; // see [R3]
      st_d[`DSOL_EV_RDY] = main_power_on && !hardwired_safety_block
                           && !alarm_active && enc_ok; // see [R5]
      st_d[`DSOL_EV_VM] = !pos_mode && (dif_abs < {10'h000, vm_w_q}); // see [R7] [R8]
      st_d[`DSOL_EV_PD] = pos_mode && (err_abs < {1'b0, pd_w_q}); // see [R9]
      case (tim_act_q)
        DSOL_PD_FILT_ZERO: st_d[`DSOL_EV_PD] = st_d[`DSOL_EV_PD] && filtered_ref_zero;
        DSOL_PD_RAW_ZERO: st_d[`DSOL_EV_PD] = st_d[`DSOL_EV_PD] && raw_ref_zero;
        default: ; // see [R11]
      endcase
    end
    ev = st_d & ~st_q;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st_q <= 5'h00;
    else st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin mapping: a signal with allocation 0 drives no pin; see [R2]
  dsol_pins_t pins_d;
  always_comb begin
    pins_d = 3'b000;
    for (int s = 0; s < `DSOL_NUM_EV; s++) begin
      for (int p = 0; p < `DSOL_NUM_PINS; p++) begin
        if (alloc_q[2*s +: 2] == 2'(p + 1) && st_q[s]) pins_d[p] = 1'b1;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) status_pins <= 3'b000;
    else status_pins <= pins_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: rising status levels set sticky bits, write one clears;
  // a set in the clearing cycle wins so no event is lost
  logic [`DSOL_NUM_EV-1:0] istat_q, istat_d, iclr;
  always_comb begin
    iclr = (wr_q && adr_q == `DSOL_OFS_IRQ_STAT) ? hwdata[`DSOL_NUM_EV-1:0] : 5'h00;
    istat_d = (istat_q & ~iclr) | ev;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_q <= 5'h00;
      irq <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq <= |(istat_d & imask_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, decoded in the address phase and registered for the data phase; unmapped reads give zero
  logic [31:0] rdat_d;
  always_comb begin
    rdat_d = 32'h00000000;
    if (rd_d) begin
      case (haddr[7:0])
        `DSOL_OFS_CTRL: rdat_d = {30'h00000000, mode_q};
        `DSOL_OFS_ALLOC: rdat_d = {22'h000000, alloc_q};
        `DSOL_OFS_ROT_THR: rdat_d = {18'h00000, rot_thr_q};
        `DSOL_OFS_VM_WIDTH: rdat_d = {25'h0000000, vm_w_q};
        `DSOL_OFS_PD_WIDTH: rdat_d = {1'b0, pd_w_q};
        `DSOL_OFS_PD_TIMING: rdat_d = {30'h00000000, tim_pend_q};
        `DSOL_OFS_STATUS: rdat_d = {24'h000000, enc_ok, tim_act_q, st_q};
        `DSOL_OFS_IRQ_STAT: rdat_d = {27'h0000000, istat_q};
        `DSOL_OFS_IRQ_MASK: rdat_d = {27'h0000000, imask_q};
        default: rdat_d = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else hrdata <= rdat_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_warn;
    @(posedge hclk) disable iff (!hresetn) tick |=> (st_q[0] == $past(warning_active));
  endproperty
  a_warn: assert property (p_warn) else $error("warning level not sampled"); // see [R1]
  property p_pin0;
    @(posedge hclk) disable iff (!hresetn)
      (alloc_q[1:0] == 2'b00 && alloc_q[3:2] == 2'b00 && alloc_q[5:4] == 2'b00
       && alloc_q[7:6] == 2'b00 && alloc_q[9:8] == 2'b00) |=> (status_pins == 3'b000);
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin driven without allocation"); // see [R2]
  property p_pinmap;
    @(posedge hclk) disable iff (!hresetn)
      (alloc_q[3:2] == 2'b10 && st_q[1]) |=> status_pins[1];
  endproperty
  a_pinmap: assert property (p_pinmap) else $error("rotation not on its pin"); // see [R2]
  property p_rot;
    @(posedge hclk) disable iff (!hresetn)
      tick |=> (st_q[1] == ($past(spd_abs) >= {2'b00, $past(rot_thr_q)}));
  endproperty
  a_rot: assert property (p_rot) else $error("rotation detect wrong"); // see [R3]
  property p_thr;
    @(posedge hclk) disable iff (!hresetn)
      ##1 (rot_thr_q >= 14'h0001 && rot_thr_q <= 14'h2710);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold out of range"); // see [R4]
  property p_rdy;
    @(posedge hclk) disable iff (!hresetn)
      (tick && (alarm_active || hardwired_safety_block || !main_power_on)) |=> !st_q[2];
  endproperty
  a_rdy: assert property (p_rdy) else $error("servo ready while blocked"); // see [R5]
  property p_abs;
    @(posedge hclk) disable iff (!hresetn)
      (tick && mode_q[1] && !abs_data_sent) |=> !st_q[2];
  endproperty
  a_abs: assert property (p_abs) else $error("ready before absolute data sent"); // see [R6]
  property p_vm_mode;
    @(posedge hclk) disable iff (!hresetn) (tick && mode_q[0]) |=> !st_q[3];
  endproperty
  a_vm_mode: assert property (p_vm_mode) else $error("speed match in position mode"); // see [R8]
  property p_pd;
    @(posedge hclk) disable iff (!hresetn)
      (tick && mode_q[0] && tim_act_q == DSOL_PD_ERR_ONLY && err_abs < {1'b0, pd_w_q})
        |=> st_q[4];
  endproperty
  a_pd: assert property (p_pd) else $error("positioning done missed"); // see [R9]
  property p_tim;
    @(posedge hclk) disable iff (!hresetn) (!restart) |=> $stable(tim_act_q);
  endproperty
  a_tim: assert property (p_tim) else $error("timing changed without restart"); // see [R11]
  property p_hold;
    @(posedge hclk) disable iff (!hresetn) (!tick) |=> $stable(st_q);
  endproperty
  a_hold: assert property (p_hold) else $error("status moved between ticks"); // see [R13]
  c_rdy: cover property (@(posedge hclk) disable iff (!hresetn) $rose(st_q[2]));
  c_pd: cover property (@(posedge hclk) disable iff (!hresetn) $rose(st_q[4]));
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule

// >>> dv/dsol_host_model.sv
// host-side partner: hands over absolute position data, then encoder power-on
// assumes send_req is raised by the bench and held while the host wants power
`timescale 1ns/1ps
module dsol_host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic send_req,
  output logic abs_data_sent,
  output logic encoder_power_on_command
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  // transfer progress, parked at full count; dropping the request restarts it
  always_comb begin
    cnt_d = (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
    if (!send_req) begin
      cnt_d = 4'h0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // the command only follows a finished data transfer, never races it
  assign abs_data_sent = (cnt_q >= 4'h8);
  assign encoder_power_on_command = (cnt_q >= 4'hC);
endmodule

// >>> dv/dsol_core_test.sv
// self-checking bench: register access over ahb-lite, status pins per control tick
// assumes one slave whose hreadyout is the bus hready, and a fixed tick period
`timescale 1ns/1ps
`include "dsol_cfg.svh"
module dsol_core_test;
  import dsol_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, send_req;
  logic filtered_ref_zero, raw_ref_zero, main_power_on, hardwired_safety_block;
  logic alarm_active, warning_active, encoder_power_on_command, abs_data_sent;
  logic [31:0] haddr, hwdata, hrdata, smp_rdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic signed [15:0] motor_speed, reference_speed;
  logic signed [31:0] position_error;
  dsol_pins_t status_pins;
  logic [3:0] smp_out;
  logic [2:0] bad [4];
  logic smp_rdy, smp_resp;
  int n_mismatch, n_compared, cyc, t, i;
  assign hready = hreadyout;
  dsol_core dsol_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .motor_speed(motor_speed),
    .reference_speed(reference_speed), .position_error(position_error),
    .filtered_ref_zero(filtered_ref_zero), .raw_ref_zero(raw_ref_zero),
    .main_power_on(main_power_on), .hardwired_safety_block(hardwired_safety_block),
    .alarm_active(alarm_active), .warning_active(warning_active),
    .encoder_power_on_command(encoder_power_on_command), .abs_data_sent(abs_data_sent),
    .status_pins(status_pins), .irq(irq));
  dsol_host_model dsol_host_model_i (.hclk(hclk), .hresetn(hresetn), .send_req(send_req),
    .abs_data_sent(abs_data_sent), .encoder_power_on_command(encoder_power_on_command));
  ////////////////////////////////////////////////////////////////////////////
  // clock, falling-edge samples (race-free reads) and the hang limit
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(negedge hclk) begin
    smp_rdata = hrdata;
    smp_rdy = hreadyout;
    smp_resp = hresp;
    smp_out = {irq, status_pins};
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // single-word bus transfer; waits are cut only by the global limit
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (smp_rdy !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (smp_rdy !== 1'b1) @(posedge hclk);
    rd = smp_rdata;
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // irq on top of the three pins
  task automatic cmp_out(input logic [3:0] exp);
    n_compared++;
    if (smp_out !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, smp_out, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    // the slave only ever answers okay
    cmp_reg({31'h00000000, smp_resp}, 32'h00000000);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp_reg(rd, exp);
  endtask
  // a full tick plus pipeline: the first tick after any input change has landed
  task automatic tick_chk(input logic [3:0] exp);
    repeat (`DSOL_CTRL_CYCLES + 4) @(posedge hclk);
    cmp_out(exp);
  endtask
  task automatic summarize();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence; reference 100 keeps speed match off until it is wanted
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata, send_req} = '0;
    {filtered_ref_zero, raw_ref_zero, main_power_on, hardwired_safety_block} = '0;
    {alarm_active, warning_active, motor_speed, position_error} = '0;
    reference_speed = 16'sd100;
    bad = '{3'b000, 3'b110, 3'b101, 3'b100};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`DSOL_OFS_ROT_THR, 32'h00000014);
    rdc(`DSOL_OFS_VM_WIDTH, 32'h0000000A);
    rdc(`DSOL_OFS_PD_WIDTH, 32'h00000007);
    rdc(`DSOL_OFS_PD_TIMING, 32'h00000000);
    rdc(`DSOL_OFS_ALLOC, 32'h00000000);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h00000000);
    // out-of-range settings are dropped, the top of the positioning width range is kept
    wr(`DSOL_OFS_ROT_THR, 32'h00000000);
    wr(`DSOL_OFS_VM_WIDTH, 32'h00000065);
    wr(`DSOL_OFS_PD_WIDTH, 32'h40000001);
    rdc(`DSOL_OFS_ROT_THR, 32'h00000014);
    rdc(`DSOL_OFS_VM_WIDTH, 32'h0000000A);
    rdc(`DSOL_OFS_PD_WIDTH, 32'h00000007);
    wr(`DSOL_OFS_PD_WIDTH, 32'h40000000);
    rdc(`DSOL_OFS_PD_WIDTH, 32'h40000000);
    wr(`DSOL_OFS_PD_WIDTH, 32'h00000007);
    // warning on pin 0, rotation on pin 1, ready on pin 2; rotation edge unmasked
    wr(`DSOL_OFS_ALLOC, 32'h00000039);
    wr(`DSOL_OFS_IRQ_MASK, 32'h00000002);
    warning_active <= 1'b1;
    main_power_on <= 1'b1;
    motor_speed <= 16'sd20;
    tick_chk(4'hF);
    rdc(`DSOL_OFS_STATUS, 32'h00000087);
    rdc(`DSOL_OFS_IRQ_STAT, 32'h00000007);
    wr(`DSOL_OFS_IRQ_STAT, 32'h00000002);
    repeat (3) @(posedge hclk);
    cmp_out(4'h7);
    wr(`DSOL_OFS_IRQ_MASK, 32'h00000000);
    warning_active <= 1'b0;
    motor_speed <= 16'sd19;
    // each missing ready condition alone, then all met
    for (i = 0; i < 4; i++) begin
      {main_power_on, hardwired_safety_block, alarm_active} <= bad[i];
      tick_chk((i == 3) ? 4'h4 : 4'h0);
    end
    wr(`DSOL_OFS_ROT_THR, 32'h00002710);
    motor_speed <= 16'sd9999;
    tick_chk(4'h4);
    motor_speed <= 16'sd10000;
    tick_chk(4'h6);
    // absolute encoder: ready waits for data handover and power-on command
    wr(`DSOL_OFS_CTRL, 32'h00000002);
    tick_chk(4'h2);
    rdc(`DSOL_OFS_STATUS, 32'h00000002);
    send_req <= 1'b1;
    tick_chk(4'h6);
    // speed match alone on pin 0, width boundary both sides
    wr(`DSOL_OFS_ALLOC, 32'h00000040);
    reference_speed <= 16'sd2000;
    motor_speed <= 16'sd1991;
    tick_chk(4'h1);
    motor_speed <= 16'sd1990;
    tick_chk(4'h0);
    wr(`DSOL_OFS_VM_WIDTH, 32'h00000064);
    motor_speed <= 16'sd2099;
    tick_chk(4'h1);
    motor_speed <= 16'sd2000;
    wr(`DSOL_OFS_CTRL, 32'h00000003);
    tick_chk(4'h0);
    // positioning done on pin 1, in position mode
    wr(`DSOL_OFS_ALLOC, 32'h00000200);
    position_error <= -32'sd6;
    tick_chk(4'h2);
    position_error <= 32'sd7;
    tick_chk(4'h0);
    wr(`DSOL_OFS_PD_WIDTH, 32'h00000003);
    position_error <= -32'sd3;
    tick_chk(4'h0);
    position_error <= 32'sd0;
    // timing select stays pending until restart, then adds its zero condition
    for (t = 1; t < 3; t++) begin
      wr(`DSOL_OFS_PD_TIMING, t);
      filtered_ref_zero <= (t == 2);
      raw_ref_zero <= 1'b0;
      tick_chk(4'h2);
      wr(`DSOL_OFS_CTRL, 32'h00000007);
      tick_chk(4'h0);
      filtered_ref_zero <= (t == 1);
      raw_ref_zero <= (t == 2);
      tick_chk(4'h2);
      rdc(`DSOL_OFS_STATUS, 32'h00000094 | (t << 5));
    end
    // the unused timing code is refused, the pending choice stays
    wr(`DSOL_OFS_PD_TIMING, 32'h00000003);
    rdc(`DSOL_OFS_PD_TIMING, 32'h00000002);
    summarize();
  end
endmodule
